// [design/dma_cfg_pkg.sv]
// package: register map, field layout and decoded types for the dma destination config block
package dma_cfg_pkg;
  // ==========================================
  // register byte offsets
  localparam logic [11:0] OFS_DMA0_DEST_ATTR = 12'h534;
  localparam logic [11:0] OFS_DMA0_NEXT_HIGH = 12'h538;
  localparam logic [11:0] OFS_DMA0_NEXT_LOW = 12'h53c;
  localparam logic [11:0] OFS_DMA1_DEST_ATTR = 12'h5b4;
  localparam logic [11:0] OFS_DMA1_NEXT_HIGH = 12'h5b8;
  localparam logic [11:0] OFS_DMA1_NEXT_LOW = 12'h5bc;
  localparam logic [11:0] OFS_DMA_MODE = 12'h5f0;
  // ==========================================
  // field positions and masks
  localparam int POS_KIND = 28;
  localparam int POS_RATE = 11;
  localparam int POS_PROTO = 8;
  localparam int POS_WIDTH = 6;
  localparam int POS_SUP = 5;
  localparam int POS_PGM = 4;
  localparam int POS_SPACE = 0;
  localparam logic [31:0] MASK_DEST_ATTR = 32'h10001fff;
  localparam logic [31:0] MASK_NEXT_LOW = 32'hfffffff9;
  localparam logic [31:0] RST_REG = 32'h00000000;
  // ==========================================
  // encodings
  localparam logic [2:0] PROTO_SCT = 3'h0;
  localparam logic [2:0] PROTO_BLT = 3'h1;
  localparam logic [2:0] PROTO_LAST = 3'h4;
  localparam logic [1:0] RATE_LAST = 2'h2;
  localparam logic [1:0] WIDTH_LAST = 2'h1;
  localparam logic [3:0] SPACE_A16 = 4'h0;
  localparam logic [3:0] SPACE_A24 = 4'h1;
  localparam logic [3:0] SPACE_A32 = 4'h2;
  localparam logic [3:0] SPACE_A64 = 4'h4;
  localparam logic [3:0] SPACE_CSR = 4'h5;
  localparam logic [5:0] AM_A16 = 6'h29;
  localparam logic [5:0] AM_A24 = 6'h39;
  localparam logic [5:0] AM_A32 = 6'h09;
  localparam logic [5:0] AM_A64 = 6'h01;
  localparam logic [5:0] AM_CSR = 6'h2f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================
  // decoded attributes handed to the engine
  typedef struct packed {
    logic to_vme;
    logic [2:0] protocol;
    logic [1:0] rate;
    logic [1:0] width_code; // 0=16,1=32,2=64 bit
    logic [5:0] am_code;
    logic attr_valid;
  } xfer_attr_type;
  // descriptor reload strobe with payload
  typedef struct packed {
    logic load;
    logic [31:0] dest_attr;
    logic [31:0] next_high;
    logic [31:0] next_low;
  } desc_load_type;
endpackage

// [design/dma_dest_cfg.sv]
// top: two-channel dma destination attribute and next descriptor registers on axi4-lite
//
// Notes on behaviour
// RL1 - bit 28 picks pci or vme destination
// RL2 - vme fields ignored for pci destination
// RL3 - rate field 160/267/320 mbps, 11b reserved
// RL4 - protocol field sct..2esst, 101b-111b reserved
// RL5 - width limit 16 or 32 bit
// RL6 - supervisor bit selects supervisory modifier
// RL7 - program bit selects program modifier
// RL8 - address space field decodes vme space
// RL9 - user spaces: am 01xx plus sup, pgm
// RL10 - software writes attributes before direct start
// RL11 - linked list reloads attributes from descriptor
// RL12 - high register holds descriptor bits 63:32
// RL13 - high register unused in direct mode
// RL14 - software seeds next descriptor address registers
// RL15 - linked list reloads high from descriptor
// RL16 - two channels, attr 534/5b4, high 538/5b8
// RL17 - low register bits 31:3, bit 0 last flag
// RL18 - width limit only for sct and blt
// RL19 - software avoids reserved encodings
`timescale 1ns/1ps
module dma_dest_cfg #(
  parameter int CHANNELS = 2
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic [11:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [11:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire dma_cfg_pkg::desc_load_type I_DESC_LOAD [CHANNELS],
  output dma_cfg_pkg::xfer_attr_type O_ATTR [CHANNELS],
  output logic [63:0] O_NEXT_DESC_ADDR [CHANNELS],
  output logic O_FINAL_DESC [CHANNELS],
  output logic O_LINKED_MODE [CHANNELS]
);
  // ==========================================
  // address decode
  // returns channel*3+reg index, or 7 for mode register, 15 for unmapped
  function automatic logic [3:0] reg_sel(input logic [11:0] a);
    case (a)
      dma_cfg_pkg::OFS_DMA0_DEST_ATTR: reg_sel = 4'h0;
      dma_cfg_pkg::OFS_DMA0_NEXT_HIGH: reg_sel = 4'h1;
      dma_cfg_pkg::OFS_DMA0_NEXT_LOW: reg_sel = 4'h2;
      dma_cfg_pkg::OFS_DMA1_DEST_ATTR: reg_sel = 4'h3;
      dma_cfg_pkg::OFS_DMA1_NEXT_HIGH: reg_sel = 4'h4;
      dma_cfg_pkg::OFS_DMA1_NEXT_LOW: reg_sel = 4'h5;
      dma_cfg_pkg::OFS_DMA_MODE: reg_sel = 4'h7;
      default: reg_sel = 4'hf;
    endcase
  endfunction

  // byte-lane merge of a write into a register with a writable mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    merge = r & m;
  endfunction

  // ==========================================
  // write channel handshake state
  logic aw_held_ff, nxt_aw_held;
  logic w_held_ff, nxt_w_held;
  logic [11:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic do_write;
  logic [3:0] wsel;

  // address and data taken in either order; response after both
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held = w_held_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    do_write = 1'b0;
    if (I_AWVALID && awready_ff) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = I_AWADDR;
    end
    if (I_WVALID && wready_ff) begin
      nxt_w_held = 1'b1;
      nxt_w_data = I_WDATA;
      nxt_w_strb = I_WSTRB;
    end
    if (aw_held_ff && w_held_ff && !bvalid_ff) begin
      do_write = 1'b1;
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (reg_sel(aw_addr_ff) == 4'hf) ? dma_cfg_pkg::RESP_SLVERR
                                                : dma_cfg_pkg::RESP_OKAY;
    end else if (bvalid_ff && I_BREADY) begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_held && !nxt_bvalid;
    nxt_wready = !nxt_w_held && !nxt_bvalid;
  end
  assign wsel = reg_sel(aw_addr_ff);

  // write channel registers
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= dma_cfg_pkg::RST_REG;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= dma_cfg_pkg::RESP_OKAY;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff <= nxt_w_held;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
    end
  end

  // ==========================================
  // per-channel configuration registers
  logic [31:0] attr_ff [CHANNELS];
  logic [31:0] high_ff [CHANNELS];
  logic [31:0] low_ff [CHANNELS];
  logic [CHANNELS-1:0] mode_ff;
  logic [CHANNELS-1:0] nxt_mode;

  // mode register: one linked-list enable bit per channel
  always_comb begin
    nxt_mode = mode_ff;
    if (do_write && wsel == 4'h7 && w_strb_ff[0]) begin
      nxt_mode = w_data_ff[CHANNELS-1:0];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_ff <= '0;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    logic [31:0] nxt_attr, nxt_high, nxt_low;
    logic [3:0] base;
    logic [3:0] space;
    logic [2:0] proto;
    logic [1:0] rate;
    logic [1:0] wlim;
    logic supervisor_select, program_space_select;
    dma_cfg_pkg::xfer_attr_type nxt_out;
    assign base = 4'(3 * c);

    // software writes; a descriptor reload in the same cycle wins
    always_comb begin
      nxt_attr = attr_ff[c];
      nxt_high = high_ff[c];
      nxt_low = low_ff[c];
      if (do_write && wsel == base) begin
        nxt_attr = merge(attr_ff[c], w_data_ff, w_strb_ff, dma_cfg_pkg::MASK_DEST_ATTR);
      end
      // RL14 software seeds address
      if (do_write && wsel == base + 4'h1) begin
        nxt_high = merge(high_ff[c], w_data_ff, w_strb_ff, 32'hffffffff);
      end
      // RL17 low word layout
      if (do_write && wsel == base + 4'h2) begin
        nxt_low = merge(low_ff[c], w_data_ff, w_strb_ff, dma_cfg_pkg::MASK_NEXT_LOW);
      end
      // RL11 RL15 descriptor reload, linked mode only
      if (I_DESC_LOAD[c].load && mode_ff[c]) begin
        nxt_attr = I_DESC_LOAD[c].dest_attr & dma_cfg_pkg::MASK_DEST_ATTR;
        nxt_high = I_DESC_LOAD[c].next_high;
        nxt_low = I_DESC_LOAD[c].next_low & dma_cfg_pkg::MASK_NEXT_LOW;
      end
    end

    // field extraction
    assign space = attr_ff[c][dma_cfg_pkg::POS_SPACE +: 4];
    assign proto = attr_ff[c][dma_cfg_pkg::POS_PROTO +: 3];
    assign rate = attr_ff[c][dma_cfg_pkg::POS_RATE +: 2];
    assign wlim = attr_ff[c][dma_cfg_pkg::POS_WIDTH +: 2];
    assign supervisor_select = attr_ff[c][dma_cfg_pkg::POS_SUP];
    assign program_space_select = attr_ff[c][dma_cfg_pkg::POS_PGM];

    // decode attributes into engine view
    always_comb begin
      nxt_out = '0;
      // RL1 destination kind
      nxt_out.to_vme = attr_ff[c][dma_cfg_pkg::POS_KIND];
      // RL2 pci ignores vme fields
      if (nxt_out.to_vme) begin
        // RL3 RL4 rate and protocol
        nxt_out.protocol = proto;
        nxt_out.rate = rate;
        // RL5 RL18 width limit
        if (proto == dma_cfg_pkg::PROTO_SCT || proto == dma_cfg_pkg::PROTO_BLT) begin
          nxt_out.width_code = wlim;
        end else begin
          nxt_out.width_code = 2'h2;
        end
        // RL6 RL7 RL8 RL9 modifier generation
        case (space)
          dma_cfg_pkg::SPACE_A16: nxt_out.am_code = dma_cfg_pkg::AM_A16;
          dma_cfg_pkg::SPACE_A24: nxt_out.am_code = dma_cfg_pkg::AM_A24;
          dma_cfg_pkg::SPACE_A32: nxt_out.am_code = dma_cfg_pkg::AM_A32;
          dma_cfg_pkg::SPACE_A64: nxt_out.am_code = dma_cfg_pkg::AM_A64;
          dma_cfg_pkg::SPACE_CSR: nxt_out.am_code = dma_cfg_pkg::AM_CSR;
          default: nxt_out.am_code = {2'b01, space[1:0], 2'b00};
        endcase
        if (space != dma_cfg_pkg::SPACE_CSR) begin
          nxt_out.am_code[2] = supervisor_select; // bit 2 set marks supervisory access
          nxt_out.am_code[1:0] = {program_space_select, ~program_space_select}; // program 10, data 01
        end
        if (space[3]) begin
          nxt_out.am_code = {2'b01, space[1:0], supervisor_select, program_space_select};
        end
        nxt_out.attr_valid = (rate <= dma_cfg_pkg::RATE_LAST)
            && (proto <= dma_cfg_pkg::PROTO_LAST) && (wlim <= dma_cfg_pkg::WIDTH_LAST)
            && (space <= dma_cfg_pkg::SPACE_A32 || space == dma_cfg_pkg::SPACE_A64
                || space == dma_cfg_pkg::SPACE_CSR || space[3:2] == 2'b10);
      end else begin
        nxt_out.attr_valid = 1'b1;
      end
    end

    // RL16 per-channel storage
    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
        attr_ff[c] <= dma_cfg_pkg::RST_REG;
        high_ff[c] <= dma_cfg_pkg::RST_REG;
        low_ff[c] <= dma_cfg_pkg::RST_REG;
        O_ATTR[c] <= '0;
        O_NEXT_DESC_ADDR[c] <= 64'h0;
        O_FINAL_DESC[c] <= 1'b0;
        O_LINKED_MODE[c] <= 1'b0;
      end else begin
        attr_ff[c] <= nxt_attr;
        high_ff[c] <= nxt_high;
        low_ff[c] <= nxt_low;
        O_ATTR[c] <= nxt_out;
        // RL12 RL13 address only offered in linked mode
        O_NEXT_DESC_ADDR[c] <= mode_ff[c] ? {high_ff[c], low_ff[c][31:3], 3'b000} : 64'h0;
        O_FINAL_DESC[c] <= low_ff[c][0];
        O_LINKED_MODE[c] <= mode_ff[c];
      end
    end
  end

  // ==========================================
  // read channel
  logic rvalid_ff, nxt_rvalid;
  logic arready_ff, nxt_arready;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (I_ARVALID && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = dma_cfg_pkg::RESP_OKAY;
      case (reg_sel(I_ARADDR))
        4'h0: nxt_rdata = attr_ff[0];
        4'h1: nxt_rdata = high_ff[0];
        4'h2: nxt_rdata = low_ff[0];
        4'h3: nxt_rdata = attr_ff[1];
        4'h4: nxt_rdata = high_ff[1];
        4'h5: nxt_rdata = low_ff[1];
        4'h7: nxt_rdata = {{(32-CHANNELS){1'b0}}, mode_ff};
        default: begin
          nxt_rdata = dma_cfg_pkg::RST_REG;
          nxt_rresp = dma_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && I_RREADY) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b0;
      rdata_ff <= dma_cfg_pkg::RST_REG;
      rresp_ff <= dma_cfg_pkg::RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      arready_ff <= nxt_arready;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // bus outputs straight from flops
  assign O_AWREADY = awready_ff;
  assign O_WREADY = wready_ff;
  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;
  assign O_ARREADY = arready_ff;
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = rdata_ff;
  assign O_RRESP = rresp_ff;

  // ==========================================
  // checks
  // RL1 kind follows bit
  AST_KIND: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL1
    1'b1 |=> O_ATTR[0].to_vme == $past(attr_ff[0][28])) else $error("kind mismatch");
  // RL2 pci ignores vme fields
  AST_PCI_IGN: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL2
    !attr_ff[1][28] |=> O_ATTR[1].am_code == 6'h00 && O_ATTR[1].protocol == 3'h0)
    else $error("vme field leaked");
  // RL9 user space modifier
  AST_USER_AM: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL9
    attr_ff[0][28] && attr_ff[0][3:2] == 2'b10 |=>
    O_ATTR[0].am_code == {2'b01, $past(attr_ff[0][1:0]), $past(attr_ff[0][5:4])})
    else $error("user modifier wrong");
  // RL18 wide protocols
  AST_WIDE: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL18
    attr_ff[0][28] && attr_ff[0][10:8] > 3'h1 |=> O_ATTR[0].width_code == 2'h2)
    else $error("width limit misapplied");
  // RL15 reload lands in the register next cycle
  AST_RELOAD: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL15
    I_DESC_LOAD[0].load && mode_ff[0] |=> high_ff[0] == $past(I_DESC_LOAD[0].next_high))
    else $error("high not reloaded");
  // RL13 no address in direct mode
  AST_DIRECT: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL13
    !mode_ff[1] |=> O_NEXT_DESC_ADDR[1] == 64'h0) else $error("address used in direct mode");
  // RL17 low reserved bits read zero
  AST_LOW_RSV: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL17
    low_ff[0][2:1] == 2'b00) else $error("low reserved bits set");
  // RL16 write lands in right channel
  AST_CH_WR: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN) // RL16
    do_write && wsel == 4'h4 && w_strb_ff == 4'hf && !(I_DESC_LOAD[1].load && mode_ff[1])
    |=> high_ff[1] == $past(w_data_ff)) else $error("channel write lost");
endmodule

// [tb/desc_engine_model.sv]
// descriptor fetch engine model driving the reload strobes of both channels
`timescale 1ns/1ps
module desc_engine_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic i_chan,
  input wire logic [95:0] i_words,
  output dma_cfg_pkg::desc_load_type o_desc [2]
);
  // ==========================================
  // reload pulse
  initial begin
    o_desc[0] = '0;
    o_desc[1] = '0;
  end
  // descriptor fields reload
  // one-cycle pulse; idle payload toggles so stale data never looks valid
  always @(posedge i_clk) begin
    for (int c = 0; c < 2; c++) begin
      if (i_go && (i_chan == c[0])) begin
        o_desc[c] <= {1'b1, i_words};
      end else begin
        o_desc[c] <= {1'b0, ~o_desc[c][95:0]};
      end
    end
  end
endmodule

// [tb/testbench.sv]
// testbench: register and reload tests for the dma destination config block
`timescale 1ns/1ps
module testbench;
  // ==========================================
  // signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hf;
  logic go = 1'b0;
  logic chan = 1'b0;
  logic [95:0] words = 96'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  dma_cfg_pkg::desc_load_type desc [2];
  dma_cfg_pkg::xfer_attr_type attr [2];
  dma_cfg_pkg::xfer_attr_type ea;
  logic [63:0] next_addr [2];
  logic final_desc [2];
  logic linked [2];
  logic [3:0] spaces [8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb};
  logic [31:0] word;
  logic [11:0] abase;
  int error_cnt = 0;
  int checked = 0;

  // clock 25 mhz
  always #20 clk = ~clk;

  dma_dest_cfg i_dut (
    .I_SYS_CLK(clk), .I_RSTN(rstn),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_DESC_LOAD(desc), .O_ATTR(attr), .O_NEXT_DESC_ADDR(next_addr),
    .O_FINAL_DESC(final_desc), .O_LINKED_MODE(linked)
  );

  desc_engine_model i_engine (
    .i_clk(clk), .i_go(go), .i_chan(chan), .i_words(words), .o_desc(desc)
  );

  // ==========================================
  // report and compare
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================
  // axi4-lite master; handshakes sampled at the falling edge before the taking edge
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    for (int n = 0; n < 40 && !hb; n++) begin
      @(negedge clk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    if (!hb) begin
      error_cnt++;
      complete_run();
    end
    check(r, er);
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ha, hr;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    for (int n = 0; n < 40 && !hr; n++) begin
      @(negedge clk);
      ha = arvalid & arready;
      hr = rvalid === 1'b1;
      r = rresp;
      d = rdata;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    if (!hr) begin
      error_cnt++;
      complete_run();
    end
    check(d, ed);
    check(r, er);
  endtask

  // descriptor reload through the engine model, then let outputs settle
  task automatic reload(input logic c, input logic [95:0] w);
    @(posedge clk);
    go <= 1'b1;
    chan <= c;
    words <= w;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // expected modifier from space, supervisor and program bits
  function automatic logic [5:0] am_exp(input logic [3:0] s, input logic supervisor_select, input logic program_space_select);
    logic [1:0] lo;
    lo = program_space_select ? 2'b10 : 2'b01;
    case (s)
      4'h0: am_exp = {dma_cfg_pkg::AM_A16[5:3], supervisor_select, lo};
      4'h1: am_exp = {dma_cfg_pkg::AM_A24[5:3], supervisor_select, lo};
      4'h2: am_exp = {dma_cfg_pkg::AM_A32[5:3], supervisor_select, lo};
      4'h5: am_exp = 6'h2f;
      default: am_exp = {2'b01, s[1:0], supervisor_select, program_space_select};
    endcase
  endfunction

  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // reset values of the attribute and high registers of both channels
    for (int i = 0; i < 4; i++) begin
      axi_read((i < 2 ? 12'h534 : 12'h5b4) + 12'(4 * (i % 2)), 32'h0, 2'h0);
    end
    // reserved bits read zero, reserved codes flagged
    axi_write(12'h534, 32'hffffffff, 2'h0);
    axi_read(12'h534, 32'h10001fff, 2'h0);
    @(negedge clk);
    check(attr[0].attr_valid, 1'b0);
    // pci destination hides every vme field
    axi_write(12'h534, 32'h00001fe5, 2'h0);
    axi_write(12'h5b4, 32'h00001fe5, 2'h0);
    @(negedge clk);
    check(attr[0], 15'h0001);
    check(attr[1], 15'h0001);
    // vme attribute sweep over both channels
    for (int i = 0; i < 8; i++) begin
      abase = i[0] ? 12'h5b4 : 12'h534;
      word = 32'h10000000 | (32'(i % 3) << 11) | (32'(i % 5) << 8) | (32'(i[0]) << 6);
      word = word | (32'(i[1]) << 5) | (32'(i[2]) << 4) | 32'(spaces[i]);
      axi_write(abase, word, 2'h0);
      axi_read(abase, word, 2'h0);
      ea.to_vme = 1'b1;
      ea.protocol = 3'(i % 5);
      ea.rate = 2'(i % 3);
      ea.width_code = (i % 5 < 2) ? {1'b0, i[0]} : 2'h2;
      ea.am_code = am_exp(spaces[i], i[1], i[2]);
      ea.attr_valid = 1'b1;
      @(negedge clk);
      check(attr[i % 2], ea);
    end
    // seed the chain on channel 0, channel 1 stays direct
    axi_write(12'h5f0, 32'h00000001, 2'h0);
    axi_write(12'h538, 32'h89abcdef, 2'h0);
    axi_write(12'h53c, 32'h1357246f, 2'h0);
    axi_read(12'h53c, 32'h13572469, 2'h0);
    axi_write(12'h5b8, 32'h0badf00d, 2'h0);
    @(negedge clk);
    check(next_addr[0], 64'h89abcdef_13572468);
    check(final_desc[0], 1'b1);
    check(next_addr[1], 64'h0);
    check({linked[1], linked[0]}, 2'b01);
    check(final_desc[1], 1'b0);
    axi_read(12'h5f0, 32'h00000001, 2'h0);
    // reload on a direct channel is dropped
    reload(1'b1, {32'h10000000, 32'h11111111, 32'h22222220});
    axi_read(12'h5b8, 32'h0badf00d, 2'h0);
    // reload on the linked channel replaces all three registers
    reload(1'b0, {32'h10000435, 32'h00000001, 32'hfeed0000});
    axi_read(12'h534, 32'h10000435, 2'h0);
    axi_read(12'h538, 32'h00000001, 2'h0);
    @(negedge clk);
    check(next_addr[0], 64'h00000001_feed0000);
    check(final_desc[0], 1'b0);
    check(attr[0], {1'b1, 3'h4, 2'h0, 2'h2, 6'h2f, 1'b1});
    // byte strobes: only lane 1 of the high word changes
    wstrb <= 4'h2;
    axi_write(12'h538, 32'h1234ab78, 2'h0);
    wstrb <= 4'hf;
    axi_read(12'h538, 32'h0000ab01, 2'h0);
    // unmapped address
    axi_write(12'h600, 32'h5a5a5a5a, 2'h2);
    axi_read(12'h600, 32'h0, 2'h2);
    complete_run();
  end
endmodule
